// *** hdl/far_pkg.sv ***
// Package for the fan acoustic ramp block: register map, fields, timing, carriers
package far_pkg;

    // Register indices (word index; byte address is four times the index)
    localparam logic [7:0]  ACR1_INDEX      = 8'h62;       // acoustic_ramp_control_1
    localparam logic [7:0]  LOCK_INDEX      = 8'h40;       // global configuration lock
    localparam logic [7:0]  STAT_INDEX      = 8'h41;       // ramp status
    localparam logic [11:0] ACR1_ADDR       = {2'h0, ACR1_INDEX, 2'h0};
    localparam logic [11:0] LOCK_ADDR       = {2'h0, LOCK_INDEX, 2'h0};
    localparam logic [11:0] STAT_ADDR       = {2'h0, STAT_INDEX, 2'h0};

    // Field positions of acoustic_ramp_control_1, the lock register and the status register
    localparam int unsigned RATE_LSB        = 0;
    localparam int unsigned RATE_MSB        = 2;
    localparam int unsigned EN_BIT          = 3;
    localparam int unsigned SYNC_BIT        = 4;
    localparam int unsigned FLOOR_BIT       = 5;
    localparam int unsigned LOCK_BIT        = 0;
    localparam int unsigned STAT_RAMP_BIT   = 8;

    // Values after reset and the off duty
    localparam logic [7:0]  ACR1_RESET      = 8'h00;
    localparam logic [7:0]  DUTY_RESET      = 8'h00;
    localparam logic [7:0]  DUTY_OFF        = 8'h00;

    // Duty increase per time slot, indexed by the rate code
    localparam logic [7:0]  RAMP_STEP [8]   = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};

    // Slot timing: code 000 walks 33% to 100% of full scale in 35 s at one count per slot
    localparam longint unsigned SYS_CLK_KHZ     = 64'd200000;
    localparam longint unsigned RAMP_FULL_MS    = 64'd35000;
    localparam longint unsigned RAMP_SPAN_STEPS = 64'd171;   // 0x54 to 0xff
    localparam longint unsigned SLOT_CYCLES_L   = (RAMP_FULL_MS * SYS_CLK_KHZ) / RAMP_SPAN_STEPS;
    localparam int unsigned     SLOT_CYCLES     = int'(SLOT_CYCLES_L);

    // Control register layout
    typedef struct packed {
        logic [1:0] rsvd;
        logic       floor_min;
        logic       sync_all;
        logic       ramp_enable_first;
        logic [2:0] rate;
    } far_ctrl_t;

    // Duty request from the fan speed calculation
    typedef struct packed {
        logic [7:0] target;
        logic [7:0] min_duty;
        logic       auto_mode;
        logic       below_start;
    } far_calc_t;

    // Speed-sense synchronisation selects toward the tach logic
    typedef struct packed {
        logic speed_sense_second;
        logic speed_sense_third;
        logic speed_sense_fourth;
    } far_sync_t;

endpackage

// *** hdl/far_ramp.sv ***
// Acoustic ramp for the first fan drive output with APB register access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module far_ramp #(
    parameter int unsigned SLOT_CYCLES = far_pkg::SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Duty request from the speed calculation
    input  wire far_pkg::far_calc_t calc,
    // Fan drive and tach sync
    output logic [7:0]             fan_drive_first,
    output far_pkg::far_sync_t     tach_sync
);

    // Register state
    far_pkg::far_ctrl_t ctrl_ff;
    logic               lock_ff;
    logic [7:0]         duty_ff;
    logic [7:0]         nxt_duty;
    logic [31:0]        slot_cnt_ff;
    logic               slot_tick;
    logic [7:0]         target;
    logic [7:0]         step;
    logic [31:0]        rdata_ff;
    logic               access;
    logic               wr_acr1;
    logic               wr_lock;

    // Decodes an APB address into a hit on one register
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] reg_addr);
        addr_hit = (a == reg_addr);
    endfunction

    // Rate code to duty increase per slot
    function automatic logic [7:0] step_of(input logic [2:0] code);
        step_of = far_pkg::RAMP_STEP[code];
    endfunction

    // APB handshake: zero wait states
    // Every register answers in its access cycle, so pready is a constant
    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = access && !(addr_hit(paddr, far_pkg::ACR1_ADDR) ||
                                 addr_hit(paddr, far_pkg::LOCK_ADDR) ||
                                 addr_hit(paddr, far_pkg::STAT_ADDR));
    assign wr_acr1 = access && pwrite && addr_hit(paddr, far_pkg::ACR1_ADDR) && !lock_ff;
    assign wr_lock = access && pwrite && addr_hit(paddr, far_pkg::LOCK_ADDR);

    // Control register, reserved bits stay zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_ff <= far_pkg::ACR1_RESET;
        end else if (wr_acr1) begin
            ctrl_ff      <= pwdata[7:0];
            ctrl_ff.rsvd <= 2'h0;
        end
    end

    // Lock bit can only be set; reset clears it
    // Sticky so that a stray write cannot reopen the control register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lock_ff <= 1'b0;
        end else if (wr_lock && pwdata[far_pkg::LOCK_BIT]) begin
            lock_ff <= 1'b1;
        end
    end

    // Read data, captured in the setup phase so it stands through the access
    // A write in the same transfer is therefore not seen by that read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (addr_hit(paddr, far_pkg::ACR1_ADDR)) begin
                rdata_ff <= {24'h00_0000, ctrl_ff};
            end else if (addr_hit(paddr, far_pkg::LOCK_ADDR)) begin
                rdata_ff <= {31'h0000_0000, lock_ff};
            end else if (addr_hit(paddr, far_pkg::STAT_ADDR)) begin
                rdata_ff <= {23'h00_0000, (duty_ff != target), duty_ff};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end
    assign prdata = rdata_ff;

    // Time slot divider: one-cycle enable per slot
    // Free running from reset, so a new target waits up to one slot for its first step
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            slot_cnt_ff <= 32'h0000_0000;
        end else if (slot_tick) begin
            slot_cnt_ff <= 32'h0000_0000;
        end else begin
            slot_cnt_ff <= slot_cnt_ff + 32'h0000_0001;
        end
    end
    assign slot_tick = (slot_cnt_ff == SLOT_CYCLES - 1);

    // Effective target: automatic mode below start threshold picks off or minimum
    always_comb begin
        if (calc.auto_mode && calc.below_start) begin
            target = ctrl_ff.floor_min ? calc.min_duty : far_pkg::DUTY_OFF;
        end else begin
            target = calc.target;
        end
    end

    assign step = step_of(ctrl_ff.rate);

    // Next duty: direct when ramping off, stepped and clamped when on
    // Clamping the last step keeps the output from hunting around the target
    always_comb begin
        nxt_duty = duty_ff;
        if (!ctrl_ff.ramp_enable_first) begin
            nxt_duty = target;
        end else if (slot_tick) begin
            if (duty_ff < target) begin
                nxt_duty = ((target - duty_ff) <= step) ? target : duty_ff + step;
            end else if (duty_ff > target) begin
                nxt_duty = ((duty_ff - target) <= step) ? target : duty_ff - step;
            end
        end
    end

    // Drive duty register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            duty_ff <= far_pkg::DUTY_RESET;
        end else begin
            duty_ff <= nxt_duty;
        end
    end
    assign fan_drive_first = duty_ff;

    // Tach synchronisation selects toward the tach logic
    // Only the second input is optional; the third and fourth always follow
    assign tach_sync.speed_sense_second = ctrl_ff.sync_all;
    assign tach_sync.speed_sense_third  = 1'b1;
    assign tach_sync.speed_sense_fourth = 1'b1;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_lock_blocks_write: assert property (
        lock_ff && access && pwrite && paddr == far_pkg::ACR1_ADDR |=> $stable(ctrl_ff))
        else $error("control register changed while locked");

    a_hold_between_slots: assert property (
        ctrl_ff.ramp_enable_first && !slot_tick && $past(ctrl_ff.ramp_enable_first) |=> $stable(duty_ff))
        else $error("duty changed outside a time slot");

    a_step_size_bound: assert property (
        ctrl_ff.ramp_enable_first && slot_tick && duty_ff < target && (target - duty_ff) > step
        |=> duty_ff == $past(duty_ff) + $past(step))
        else $error("ramp step not the selected increase");

    a_slot_period: assert property (
        slot_tick |=> !slot_tick [*8])
        else $error("slot enable repeated too soon");

    a_direct_when_off: assert property (
        !ctrl_ff.ramp_enable_first |=> duty_ff == $past(target))
        else $error("duty not taken directly with ramp off");

    a_sync_second: assert property (
        tach_sync.speed_sense_second == ctrl_ff.sync_all && tach_sync.speed_sense_third)
        else $error("sync select does not follow control bit");

    a_sync_clear: assert property (
        !ctrl_ff.sync_all |-> !tach_sync.speed_sense_second && tach_sync.speed_sense_fourth)
        else $error("second speed sense synced with bit clear");

    a_floor_target: assert property (
        calc.auto_mode && calc.below_start && !ctrl_ff.ramp_enable_first
        |=> duty_ff == ($past(ctrl_ff.floor_min) ? $past(calc.min_duty) : 8'h00))
        else $error("below start duty wrong");

    a_no_overshoot: assert property (
        ctrl_ff.ramp_enable_first && duty_ff <= target && $stable(target) |=> duty_ff <= $past(target))
        else $error("ramp overshot the target");

    a_no_undershoot: assert property (
        ctrl_ff.ramp_enable_first && duty_ff >= target && $stable(target) |=> duty_ff >= $past(target))
        else $error("ramp undershot the target");

    // Register access checks
    a_lock_sticky: assert property (
        lock_ff |=> lock_ff)
        else $error("lock bit cleared without reset");

    a_ctrl_write_lands: assert property (
        wr_acr1 |=> ctrl_ff == {2'h0, $past(pwdata[5:0])})
        else $error("unlocked control write did not land");

    a_lock_read: assert property (
        psel && !penable && !pwrite && paddr == far_pkg::LOCK_ADDR
        |=> prdata == {31'h0000_0000, $past(lock_ff)})
        else $error("lock read data wrong");

    a_status_read: assert property (
        psel && !penable && !pwrite && paddr == far_pkg::STAT_ADDR
        |=> prdata == {23'h00_0000, $past(duty_ff != target), $past(duty_ff)})
        else $error("status read data wrong");

    a_slverr_in_access: assert property (
        pslverr |-> access)
        else $error("slave error outside an access cycle");

    a_mapped_no_error: assert property (
        access && paddr == far_pkg::ACR1_ADDR |-> !pslverr)
        else $error("slave error on the control register");

    a_unmapped_ignored: assert property (
        access && pwrite && pslverr |=> $stable(ctrl_ff) && $stable(lock_ff))
        else $error("unmapped write changed a register");

    // Slot divider checks
    a_slot_bound: assert property (
        slot_cnt_ff < SLOT_CYCLES)
        else $error("slot counter past its period");

    a_slot_advance: assert property (
        !slot_tick |=> slot_cnt_ff == $past(slot_cnt_ff) + 32'h0000_0001)
        else $error("slot counter did not advance");

    a_slot_wrap: assert property (
        slot_tick |=> slot_cnt_ff == 32'h0000_0000)
        else $error("slot counter did not wrap");

    // Ramp step checks
    a_step_down_bound: assert property (
        ctrl_ff.ramp_enable_first && slot_tick && duty_ff > target && (duty_ff - target) > step
        |=> duty_ff == $past(duty_ff) - $past(step))
        else $error("downward step not the selected decrease");

    a_clamp_up: assert property (
        ctrl_ff.ramp_enable_first && slot_tick && duty_ff < target && (target - duty_ff) <= step
        |=> duty_ff == $past(target))
        else $error("last upward step not clamped to target");

    a_clamp_down: assert property (
        ctrl_ff.ramp_enable_first && slot_tick && duty_ff > target && (duty_ff - target) <= step
        |=> duty_ff == $past(target))
        else $error("last downward step not clamped to target");

    a_hold_at_target: assert property (
        ctrl_ff.ramp_enable_first && duty_ff == target |=> $stable(duty_ff))
        else $error("duty moved away from a reached target");

    a_tick_moves: assert property (
        ctrl_ff.ramp_enable_first && slot_tick && duty_ff != target |=> !$stable(duty_ff))
        else $error("slot passed without a ramp step");

    // Target selection and speed-sense sync checks
    a_floor_off: assert property (
        calc.auto_mode && calc.below_start && !ctrl_ff.floor_min |-> target == 8'h00)
        else $error("below start target not off");

    a_floor_min_duty: assert property (
        calc.auto_mode && calc.below_start && ctrl_ff.floor_min |-> target == calc.min_duty)
        else $error("below start target not the minimum duty");

    a_target_follows: assert property (
        !(calc.auto_mode && calc.below_start) |-> target == calc.target)
        else $error("target not taken from the calculation");

    a_sync_follows_bit: assert property (
        ctrl_ff.sync_all |-> tach_sync.speed_sense_second && tach_sync.speed_sense_fourth)
        else $error("speed sense not synced with bit set");

    // Scenario covers
    c_ramp_up: cover property (ctrl_ff.ramp_enable_first && slot_tick && duty_ff < target);
    c_ramp_down: cover property (ctrl_ff.ramp_enable_first && slot_tick && duty_ff > target);
    c_locked_write: cover property (lock_ff && access && pwrite && paddr == far_pkg::ACR1_ADDR);
    c_floor_min: cover property (calc.auto_mode && calc.below_start && ctrl_ff.floor_min);
    c_clamp_step: cover property (ctrl_ff.ramp_enable_first && slot_tick && duty_ff < target && (target - duty_ff) < step);

endmodule // far_ramp

`default_nettype wire

// *** test/far_fan_model.sv ***
// Fan model on the first drive output: counts duty changes it is driven with
`timescale 1ns/10ps
`default_nettype none
module far_fan_model (
    // Clock and count clear
    input  wire logic       sys_clk,
    input  wire logic       clr,
    // Drive from the block
    input  wire logic [7:0] drive,
    output logic [7:0]      n_changes_ff
);
    logic [7:0] last_ff;
    // Count every step the fan is asked to take
    always_ff @(posedge sys_clk) begin
        last_ff <= drive;
        if (clr) begin
            n_changes_ff <= 8'h00;
        end else if (drive !== last_ff) begin
            n_changes_ff <= n_changes_ff + 8'h01;
        end
    end
endmodule // far_fan_model
`default_nettype wire

// *** test/fan_pwm_acoustic_ramp_bench.sv ***
// Self-checking bench for the fan acoustic ramp block
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_acoustic_ramp_bench;
    localparam int SLOT = 16;
    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fan_clr = 1'b1;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, rd;
    logic               pready, pslverr, err;
    logic [7:0]         fan_drive_first, n_chg;
    far_pkg::far_calc_t calc = '0;
    far_pkg::far_sync_t tach_sync;
    int                 n_errors = 0, total_checks = 0;
    int                 steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

    // Clock at 200 MHz
    always #2.5 sys_clk = ~sys_clk;

    far_ramp #(.SLOT_CYCLES(SLOT)) u_dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .calc, .fan_drive_first, .tach_sync);
    far_fan_model u_fan (.sys_clk, .clr(fan_clr), .drive(fan_drive_first), .n_changes_ff(n_chg));

    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Reset value, reserved bits, unmapped address, speed-sense sync
    task automatic t_regs;
        apb(12'h3fc, 1'b1, 32'hff);
        chk({31'h0000_0000, err}, 32'h1); // unmapped write
        apb(far_pkg::ACR1_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h0); // reset value
        apb(far_pkg::LOCK_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h0); // lock reset value
        apb(12'h3fc, 1'b0, 32'h0);
        chk(rd, 32'h0); // unmapped read data
        chk({31'h0000_0000, err}, 32'h1); // unmapped
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'hff);
        apb(far_pkg::ACR1_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h3f); // reserved bits
        chk(tach_sync, 3'b111);
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'h0);
        chk(tach_sync, 3'b011);
    endtask

    // Ramp off: target taken at once, floor choice in automatic mode
    task automatic t_direct;
        calc.target <= 8'h40;
        calc.min_duty <= 8'h33;
        repeat (2) @(negedge sys_clk);
        chk(fan_drive_first, 8'h40);
        @(posedge sys_clk);
        calc.auto_mode <= 1'b1;
        calc.below_start <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(fan_drive_first, 8'h00);
        @(posedge sys_clk);
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'h20);
        @(negedge sys_clk);
        chk(fan_drive_first, 8'h33);
        @(posedge sys_clk);
        calc.auto_mode <= 1'b0;
        calc.below_start <= 1'b0;
    endtask

    // Ramp from 0 to 100 counts with one rate code
    task automatic t_ramp(input int c);
        int n;
        calc.target <= 8'h00;
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'h0);
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'h08 | c);
        fan_clr <= 1'b1;
        calc.target <= 8'h64;
        @(posedge sys_clk);
        fan_clr <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (fan_drive_first === 8'h00 && n < 3 * SLOT);
        chk(fan_drive_first, steps[c]);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (fan_drive_first === steps[c] && n < 3 * SLOT);
        chk(n, SLOT);
        repeat (110 * SLOT) @(negedge sys_clk);
        chk(fan_drive_first, 8'h64);
        chk(n_chg, (100 + steps[c] - 1) / steps[c]);
        @(posedge sys_clk);
        apb(far_pkg::STAT_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h64);
        fan_clr <= 1'b1;
        calc.target <= 8'h00;
        @(posedge sys_clk);
        fan_clr <= 1'b0;
        repeat ((100 / steps[c] + 3) * SLOT) @(negedge sys_clk);
        chk(fan_drive_first, 8'h00);
        chk(n_chg, (100 + steps[c] - 1) / steps[c]);
        @(posedge sys_clk);
    endtask

    // Lock makes the control register read-only
    task automatic t_lock;
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'h15);
        apb(far_pkg::LOCK_ADDR, 1'b1, 32'h1);
        apb(far_pkg::LOCK_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h1);
        apb(far_pkg::ACR1_ADDR, 1'b1, 32'h2a);
        apb(far_pkg::ACR1_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h15);
        chk(tach_sync, 3'b111);
    endtask

    // Verdict and end of run
    task automatic finish_test;
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs;
        t_direct;
        for (int c = 0; c < 8; c++) begin
            t_ramp(c);
        end
        t_lock;
        finish_test;
    end

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        finish_test;
    end
endmodule // fan_pwm_acoustic_ramp_bench
`default_nettype wire
